// ### include/fsc_pkg.sv
// constants for the flash status and identification host controller
// What this block does
// - host checks ready before error bits
// - command 90 enters identification mode
// - id mode lasts until next command
// - command 70 selects status read
// - host raises enable between status reads
// - software clears supply bit before retrying
// - command 50 clears error flags
package fsc_pkg;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR       = 8'h50;
    localparam int         BIT_READY       = 7;
    localparam int         BIT_SUSPENDED   = 6;
    localparam int         BIT_ERASE_ERR   = 5;
    localparam int         BIT_WRITE_ERR   = 4;
    localparam int         BIT_SUPPLY_LOW  = 3;
    localparam logic [7:0] STATUS_MASK     = 8'hf8;
    localparam logic [19:0] ID_MFR_ADDR    = 20'h00000;
    localparam logic [19:0] ID_DEV_ADDR    = 20'h00001;
    // own register map, word offsets on the software port
    localparam logic [3:0] REG_CMD         = 4'h0;
    localparam logic [3:0] REG_STATUS      = 4'h1;
    localparam logic [3:0] REG_MFR_ID      = 4'h2;
    localparam logic [3:0] REG_DEV_ID      = 4'h3;
    localparam logic [3:0] REG_CTRL        = 4'h4;
    localparam logic [2:0] OP_STATUS       = 3'h0;
    localparam logic [2:0] OP_CLEAR        = 3'h1;
    localparam logic [2:0] OP_READ_ID      = 3'h2;
    // bus timing at 25 MHz: each phase a whole number of 40 ns cycles
    localparam int         CLK_NS          = 40;
    localparam int         ACCESS_NS       = 120;
    localparam int         WE_PULSE_NS     = 60;
    localparam logic [3:0] ACCESS_CYC      = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WE_CYC          = 4'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    typedef enum logic [2:0] {
        FSC_IDLE   = 3'b000,
        FSC_WR     = 3'b001,
        FSC_WR_REC = 3'b010,
        FSC_RD     = 3'b011,
        FSC_RD_REC = 3'b100
    } fsc_state_e;
endpackage

// ### design/fsc_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module fsc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rst,     // async reset
    input  wire logic [W-1:0] d,       // pin level
    output logic      [W-1:0] q        // synchronised level
);
    logic [W-1:0] meta;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // fsc_sync

// ### design/fsc_host.sv
// host controller issuing status, clear and id commands to the flash
`timescale 1ns/10ps
module fsc_host (
    input  wire logic        sys_clk,     // 25 MHz clock
    input  wire logic        rst,         // async reset, high
    input  wire logic [3:0]  reg_addr,    // software register index
    input  wire logic [7:0]  reg_wdata,   // software write data
    input  wire logic        reg_wr,      // write strobe
    input  wire logic        reg_rd,      // read strobe
    output logic      [7:0]  reg_rdata,   // read data, next cycle
    output logic      [19:0] flash_addr,  // flash address
    output logic      [7:0]  flash_dq_o,  // data driven to flash
    output logic             flash_dq_oe, // high while driving dq
    input  wire logic [7:0]  flash_dq_i,  // data from flash
    output logic             chip_en_n,   // chip enable, low active
    output logic             out_en_n,    // output enable, low active
    output logic             write_en_n,  // write enable, low active
    input  wire logic        ready_busy_out // flash ready pin
);
    typedef struct packed {
        fsc_pkg::fsc_state_e st;
        logic [3:0]  cnt;
        logic [2:0]  op;
        logic [1:0]  step;
        logic        busy;
        logic [7:0]  status;
        logic [7:0]  mfr_id;
        logic [7:0]  dev_id;
        logic [7:0]  rdata;
        logic [19:0] addr;
        logic [7:0]  dq;
        logic        dq_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } fsc_state_s;

    fsc_state_s s;
    fsc_state_s next_s;
    logic [8:0] pin_sync;

    fsc_sync #(.W(9)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({ready_busy_out, flash_dq_i}),
        .q       (pin_sync)
    );

    always_comb begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == fsc_pkg::REG_STATUS) begin
                next_s.rdata = s.status;
            end else if (reg_addr == fsc_pkg::REG_MFR_ID) begin
                next_s.rdata = s.mfr_id;
            end else if (reg_addr == fsc_pkg::REG_DEV_ID) begin
                next_s.rdata = s.dev_id;
            end else if (reg_addr == fsc_pkg::REG_CTRL) begin
                next_s.rdata = {7'h00, s.busy};
            end
        end
        if (reg_wr && reg_addr == fsc_pkg::REG_CMD && !s.busy) begin
            next_s.op   = reg_wdata[2:0];
            next_s.busy = 1'b1;
            next_s.step = 2'h0;
        end
        case (s.st)
            fsc_pkg::FSC_IDLE: begin
                if (s.busy) begin
                    next_s.ce_n  = 1'b0;
                    next_s.we_n  = 1'b0;
                    next_s.dq_oe = 1'b1;
                    next_s.cnt   = fsc_pkg::WE_CYC;
                    next_s.st    = fsc_pkg::FSC_WR;
                    next_s.addr  = (s.step == 2'h2) ? fsc_pkg::ID_DEV_ADDR
                                                     : fsc_pkg::ID_MFR_ADDR;
                    // no write or erase issued here; software sends clear before retrying
                    if (s.op == fsc_pkg::OP_CLEAR) begin
                        next_s.dq = fsc_pkg::CMD_CLEAR;
                    end else if (s.op == fsc_pkg::OP_READ_ID) begin
                        next_s.dq = fsc_pkg::CMD_READ_ID;
                    end else begin
                        next_s.dq = fsc_pkg::CMD_READ_STATUS;
                    end
                    // id mode persists, so the second id read needs no new write
                    if (s.step != 2'h0) begin
                        next_s.we_n  = 1'b1;
                        next_s.dq_oe = 1'b0;
                        next_s.oe_n  = 1'b0;
                        next_s.cnt   = fsc_pkg::ACCESS_CYC;
                        next_s.st    = fsc_pkg::FSC_RD;
                    end
                end
            end
            fsc_pkg::FSC_WR: begin
                if (s.cnt > 4'h1) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.we_n = 1'b1;
                    next_s.st   = fsc_pkg::FSC_WR_REC;
                end
            end
            fsc_pkg::FSC_WR_REC: begin
                next_s.ce_n  = 1'b1;
                next_s.dq_oe = 1'b0;
                if (s.op == fsc_pkg::OP_CLEAR) begin
                    next_s.busy = 1'b0;
                    next_s.st   = fsc_pkg::FSC_IDLE;
                end else begin
                    next_s.step = 2'h1;
                    next_s.st   = fsc_pkg::FSC_IDLE;
                end
            end
            fsc_pkg::FSC_RD: begin
                // sample late, after the device latched at the later enable edge
                if (s.cnt > 4'h1) begin
                    next_s.cnt = s.cnt - 4'h1;
                end else begin
                    next_s.oe_n = 1'b1;
                    next_s.ce_n = 1'b1;
                    next_s.st   = fsc_pkg::FSC_RD_REC;
                    if (s.op == fsc_pkg::OP_STATUS) begin
                        next_s.status = pin_sync[7:0] & fsc_pkg::STATUS_MASK;
                    end else if (s.step == 2'h1) begin
                        next_s.mfr_id = pin_sync[7:0];
                    end else begin
                        next_s.dev_id = pin_sync[7:0];
                    end
                end
            end
            fsc_pkg::FSC_RD_REC: begin
                next_s.st = fsc_pkg::FSC_IDLE;
                if (s.op == fsc_pkg::OP_READ_ID && s.step == 2'h1) begin
                    next_s.step = 2'h2;
                end else if (s.op == fsc_pkg::OP_STATUS
                             && !s.status[fsc_pkg::BIT_READY]) begin
                    // errors only count once a fresh read shows ready
                    // pin high alone leaves a stale latch: read once more
                    if (pin_sync[8]) begin
                        next_s.step = 2'h1;
                    end else begin
                        next_s.st   = fsc_pkg::FSC_RD_REC;
                    end
                end else begin
                    next_s.busy = 1'b0;
                    next_s.step = 2'h0;
                end
            end
            default: begin
                next_s.st = fsc_pkg::FSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s       <= '0;
            s.st    <= fsc_pkg::FSC_IDLE;
            s.ce_n  <= 1'b1;
            s.oe_n  <= 1'b1;
            s.we_n  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata   = s.rdata;
    assign flash_addr  = s.addr;
    assign flash_dq_o  = s.dq;
    assign flash_dq_oe = s.dq_oe;
    assign chip_en_n   = s.ce_n;
    assign out_en_n    = s.oe_n;
    assign write_en_n  = s.we_n;

    a_no_contention: assert property (@(posedge sys_clk) disable iff (rst)
        !(s.dq_oe && !s.oe_n)) else $error("host drives dq while output enabled");
    a_enable_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(s.oe_n) |-> s.ce_n) else $error("chip enable held across reads");
    a_reserved_mask: assert property (@(posedge sys_clk) disable iff (rst)
        s.status[2:0] == 3'h0) else $error("reserved status bits kept");
    a_clear_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.we_n) && s.op == fsc_pkg::OP_CLEAR) |-> s.dq == fsc_pkg::CMD_CLEAR)
        else $error("clear op wrote wrong code");
    a_id_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.we_n) && s.op == fsc_pkg::OP_READ_ID) |-> s.dq == fsc_pkg::CMD_READ_ID)
        else $error("id op wrote wrong code");
    a_status_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(s.we_n) && s.op == fsc_pkg::OP_STATUS) |-> s.dq == fsc_pkg::CMD_READ_STATUS)
        else $error("status op wrote wrong code");
    a_we_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s.we_n) |-> !s.we_n [*2] ##1 s.we_n) else $error("write pulse length");
    a_busy_end: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(s.busy) |-> s.ce_n && s.oe_n) else $error("done with bus active");
    c_clear: cover property (@(posedge sys_clk) $fell(s.busy) && s.op == fsc_pkg::OP_CLEAR);
    c_id: cover property (@(posedge sys_clk) $fell(s.busy) && s.op == fsc_pkg::OP_READ_ID);
    c_status: cover property (@(posedge sys_clk) $fell(s.busy) && s.op == fsc_pkg::OP_STATUS);
endmodule // fsc_host

// ### sim/fsc_flash_model.sv
// behavioural flash device: command decode, status latch, id codes
`timescale 1ns/10ps
module fsc_flash_model #(
    parameter logic [7:0] MFR_ID = 8'h3c, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h5a  // arbitrary value
) (
    input  wire logic [19:0] addr,       // address pins
    input  wire logic [7:0]  din,        // data bus level
    input  wire logic        ce_n,       // chip enable, low active
    input  wire logic        oe_n,       // output enable, low active
    input  wire logic        we_n,       // write enable, low active
    input  wire logic        live_ready, // write machine idle
    input  wire logic        live_susp,  // erase suspended
    input  wire logic [2:0]  err_set,    // erase, write, supply error pulses
    output logic      [7:0]  dout,       // data driven by device
    output logic             ready_pin   // ready/busy pin
);
    logic [7:0] cmd = 8'h70;
    logic [2:0] errs = 3'h0;
    logic [7:0] latch = 8'h00;
    logic [7:0] rd_val;
    always @(err_set) errs = errs | err_set;
    always @(posedge we_n) if (!ce_n) begin
        cmd = din;
        if (din == 8'h50) errs = 3'h0;
    end
    // capture at the later of the two falling enables only
    always @(negedge (ce_n | oe_n)) begin
        latch = {live_ready, live_susp, errs, 3'b101};
    end
    // id codes follow the address live, so an address change on the enable edge cannot race
    assign rd_val = (cmd == 8'h90) ? (addr[0] ? DEV_ID : MFR_ID) : latch;
    // released bus shows the inverse so stale data never matches
    assign dout = (!ce_n && !oe_n) ? rd_val : ~rd_val;
    assign ready_pin = live_ready;
endmodule // fsc_flash_model

// ### sim/tb.sv
// testbench for the flash status and id host controller
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
    logic        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, dq_o, dq_m, bus, d;
    logic [19:0] fa;
    logic        ce_n, oe_n, we_n, dq_oe, rdy;
    logic        live_ready = 1, live_susp = 0;
    logic [2:0]  err_set = 3'h0;
    int          n_fail = 0, comparisons = 0, cyc = 0, t0;
    always #20 sys_clk = ~sys_clk;
    assign bus = dq_oe ? dq_o : dq_m;
    fsc_host uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa),
        .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(bus), .chip_en_n(ce_n),
        .out_en_n(oe_n), .write_en_n(we_n), .ready_busy_out(rdy));
    fsc_flash_model m (.addr(fa), .din(bus), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .live_ready(live_ready), .live_susp(live_susp), .err_set(err_set),
        .dout(dq_m), .ready_pin(rdy));
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // start an op and poll the busy flag with a bound
    task op(input logic [2:0] c);
        logic [7:0] s;
        wr(fsc_pkg::REG_CMD, {5'h00, c});
        repeat (2) @(posedge sys_clk);
        s = 8'h01;
        for (int i = 0; i < 3000 && s[0] !== 1'b0; i++) rd(fsc_pkg::REG_CTRL, s);
        `CHK(s[0], 1'b0)
    endtask
    task t_id;
        op(fsc_pkg::OP_READ_ID);
        rd(fsc_pkg::REG_MFR_ID, d);
        `CHK(d, 8'h3c)
        rd(fsc_pkg::REG_DEV_ID, d);
        `CHK(d, 8'h5a)
        rd(4'hf, d);
        `CHK(d, 8'h00)
        $display("test id done");
    endtask
    // each error flag pulsed then dropped must stick until cleared
    task t_flags;
        for (int k = 0; k < 3; k++) begin
            @(posedge sys_clk) err_set <= 3'(3'b001 << k);
            @(posedge sys_clk) err_set <= 3'h0;
            op(fsc_pkg::OP_STATUS);
            rd(fsc_pkg::REG_STATUS, d);
            `CHK(d, {2'b10, 3'(3'b001 << k), 3'b000})
            op(fsc_pkg::OP_CLEAR);
            op(fsc_pkg::OP_STATUS);
            rd(fsc_pkg::REG_STATUS, d);
            `CHK(d, 8'h80)
        end
        $display("test flags done");
    endtask
    task t_susp;
        @(posedge sys_clk) begin live_susp <= 1'b1; err_set <= 3'b110; end
        op(fsc_pkg::OP_STATUS);
        rd(fsc_pkg::REG_STATUS, d);
        `CHK(d, 8'hf0)
        op(fsc_pkg::OP_CLEAR);
        @(posedge sys_clk) begin live_susp <= 1'b1; err_set <= 3'h0; end
        op(fsc_pkg::OP_STATUS);
        rd(fsc_pkg::REG_STATUS, d);
        `CHK(d, 8'hc0)
        @(posedge sys_clk) live_susp <= 1'b0;
        $display("test suspend done");
    endtask
    // machine busy for a while: host must wait for the ready pin, then re-read the status
    task t_busy;
        @(posedge sys_clk) live_ready <= 1'b0;
        t0 = cyc;
        fork
            begin
                repeat (300) @(posedge sys_clk);
                live_ready <= 1'b1;
            end
        join_none
        op(fsc_pkg::OP_STATUS);
        `CHK(1'(cyc - t0 >= 300), 1'b1)
        rd(fsc_pkg::REG_STATUS, d);
        `CHK(d, 8'h80)
        $display("test busy done");
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        `CHK({ce_n, oe_n, we_n, dq_oe}, 4'b1110)
        t_id();
        t_flags();
        t_susp();
        t_busy();
        t_id();
        final_report();
    end
endmodule // tb
